/* File: design/lfwk_corr.sv */
// Purpose: One channel correlator on the sliced half-bit stream
// Assumes: sample is one cycle per half-bit
// Notes:   Window restarts after each hit
`timescale 1ns/1ps
`default_nettype none
`include "lfwk_defs.svh"

module lfwk_corr (
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       rstn,
   // Stream
   input  wire logic       sample,
   input  wire logic       din,
   // Control
   input  wire logic       enable,
   input  wire logic       clr,
   input  wire logic [1:0] tol,
   // Result
   output var  logic       hit,
   output var  logic       running
);

   localparam logic [15:0] PAT = `LFWK_PATTERN;

   logic [15:0] sh;
   logic [15:0] cand;
   logic [4:0]  fill;
   logic [4:0]  zerr;
   logic [5:0]  idle;
   logic        match;

   always_comb begin
      cand = {sh[14:0], din};
      zerr = 5'h00;
      for (int i = 0; i < 16; i++) begin
         zerr = zerr + 5'(cand[i] & ~PAT[i]);
      end
      // All one half-bits exact, zero errors up to tol
      match = ((cand & PAT) == PAT) && (zerr <= {3'b000, tol})
              && (fill >= 5'd15);
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn || clr || !enable) begin
         sh      <= '0;
         fill    <= '0;
         idle    <= '0;
         hit     <= 1'b0;
         running <= 1'b0;
      end else begin
         hit <= 1'b0;
         if (sample) begin
            if (din) begin
               // Data resumes a stopped correlator
               running <= 1'b1;
               idle    <= '0;
            end else if (idle == 6'(`LFWK_IDLE_HB - 1)) begin
               running <= 1'b0;
            end else begin
               idle <= idle + 1'b1;
            end
            if (running || din) begin
               if (match) begin
                  hit  <= 1'b1;
                  sh   <= '0;
                  fill <= '0;
               end else begin
                  sh   <= cand;
                  fill <= (fill == 5'd16) ? fill : fill + 1'b1;
               end
            end else begin
               sh   <= '0;
               fill <= '0;
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: design/lfwk_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 32-bit register words on a plain strobe port
// Notes:   Included by bare name
`ifndef LFWK_DEFS_SVH
`define LFWK_DEFS_SVH

// ==========================================================
// Register offsets
`define LFWK_OFF_CTRL   8'h00
`define LFWK_OFF_ANA    8'h04
`define LFWK_OFF_STAT   8'h08

// ==========================================================
// Field positions
`define LFWK_CTRL_DBL   0
`define LFWK_CTRL_TOL   1
`define LFWK_CTRL_CRST  3
`define LFWK_CTRL_WCLR  4
`define LFWK_CTRL_SLOPE 5
`define LFWK_ANA_EN     0
`define LFWK_ANA_ATT    3
`define LFWK_ANA_SHORT  6
`define LFWK_ANA_ROT    7
`define LFWK_STAT_WAKE  0
`define LFWK_STAT_HIT   1
`define LFWK_STAT_RUN   4

// ==========================================================
// Reset values
`define LFWK_CTRL_RST   6'h00
`define LFWK_ANA_RST    9'h007

// ==========================================================
// Pattern and timing
`define LFWK_PATTERN    16'h9669
`define LFWK_CLK_HZ     200_000_000
`define LFWK_XTAL_HZ    32_768
`define LFWK_HB_DIV     12
`define LFWK_ART_S      7200
`define LFWK_IDLE_HB    32
`define LFWK_DBL_WIN    18

`endif

/* File: design/lfwk_div.sv */
// Purpose: Enable-gated divider giving a one-cycle tick
// Assumes: en is a one-cycle pulse or a level
// Notes:   Tick is registered
`timescale 1ns/1ps
`default_nettype none

module lfwk_div #(
   parameter int unsigned DIV = 12,
   parameter int unsigned W   = 4
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rstn,
   // Rate
   input  wire logic en,
   output var  logic tick
);

   logic [W-1:0] cnt;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (en) begin
            if (cnt == W'(DIV - 1)) begin
               cnt  <= '0;
               tick <= 1'b1;
            end else begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   end

endmodule

`default_nettype wire

/* File: design/lfwk_pkg.sv */
// Purpose: Types used by the wakeup correlator top
// Assumes: Nothing
// Notes:   Constants live in lfwk_defs.svh
`default_nettype none

package lfwk_pkg;

   typedef struct packed {
      logic       slope;
      logic       wclr;
      logic       crst;
      logic [1:0] tol;
      logic       dbl;
   } lfwk_ctrl_t;

   typedef struct packed {
      logic [1:0] rot;
      logic       shrt;
      logic [2:0] att;
      logic [2:0] en;
   } lfwk_ana_t;

   typedef enum logic {
      DBL_IDLE,
      DBL_ARMED
   } lfwk_dbl_t;

endpackage

`default_nettype wire

/* File: design/lfwk_top.sv */
// Purpose: Three-channel wakeup pattern correlator with wake output
// Assumes: Sliced data inputs synchronous to ref_clk
// Notes:   Crystal rate made by a divider enable
//
// What this block does
// - Sample half-bits at crystal clock divided by twelve.
// - One Manchester bit is two half-bits.
// - Each correlator finds the fixed 16 half-bit wakeup pattern.
// - Double option needs the pattern twice before waking.
// - Wake output low after a match, held low until cleared.
// - A control bit resets the correlators.
// - Correlator stops when idle and resumes on data.
// - Error tolerance is chosen by register.
// - Counter on the crystal clock wakes about every two hours.
// - Correlator logic runs on ref_clk, sampling on the crystal-rate divide-by-twelve tick.
// - Power-on reset returns registers to defaults.
// - Wake output high during power-on reset.
// - Wake output goes low when power-on reset ends.
// - Register field selects the antenna rotator mode.
// - Register bit switches each channel's input attenuator.
// - Register bit shorts the inputs for offset measurement.
// - Register bit chooses high or low amplifier slope.
// - Wake cleared by toggling the clear bit high then low.
// - Channel detections are ORed into one wake output.
// - All one half-bits exact; zero errors 0 to 3 allowed.
// - Pattern is Manchester 96 hex, MSB first.
`timescale 1ns/1ps
`default_nettype none
`include "lfwk_defs.svh"

module lfwk_top #(
   parameter int unsigned XTAL_DIV  = `LFWK_CLK_HZ / `LFWK_XTAL_HZ,
   parameter int unsigned ART_TICKS = `LFWK_ART_S * `LFWK_XTAL_HZ
) (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   // Register port
   input  wire logic [7:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output var  logic [31:0] rdata,
   // Sliced half-bit streams
   input  wire logic [2:0]  hb_data,
   // Wake output, active low
   output var  logic        wake_n,
   // Analog controls
   output var  logic [2:0]  chan_en,
   output var  logic [2:0]  atten_en,
   output var  logic        input_short,
   output var  logic [1:0]  rot_sel,
   output var  logic        slope_high
);

   // =======================================================
   // Registers
   lfwk_pkg::lfwk_ctrl_t ctrl;
   lfwk_pkg::lfwk_ana_t  ana;
   lfwk_pkg::lfwk_dbl_t  dbl_state;

   logic        wr_ctrl;
   logic        wr_ana;
   logic        wclr_fall;
   logic [31:0] rd_val;

   assign wr_ctrl = wr && (addr == `LFWK_OFF_CTRL);
   assign wr_ana  = wr && (addr == `LFWK_OFF_ANA);
   // Clear acts on the high-to-low half of the toggle
   assign wclr_fall = wr_ctrl && ctrl.wclr
                      && !wdata[`LFWK_CTRL_WCLR];

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ctrl <= `LFWK_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl.dbl   <= wdata[`LFWK_CTRL_DBL];
         ctrl.tol   <= wdata[`LFWK_CTRL_TOL +: 2];
         ctrl.crst  <= wdata[`LFWK_CTRL_CRST];
         ctrl.wclr  <= wdata[`LFWK_CTRL_WCLR];
         ctrl.slope <= wdata[`LFWK_CTRL_SLOPE];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ana <= `LFWK_ANA_RST;
      end else if (wr_ana) begin
         ana.en   <= wdata[`LFWK_ANA_EN +: 3];
         ana.att  <= wdata[`LFWK_ANA_ATT +: 3];
         ana.shrt <= wdata[`LFWK_ANA_SHORT];
         ana.rot  <= wdata[`LFWK_ANA_ROT +: 2];
      end
   end

   assign chan_en     = ana.en;
   assign atten_en    = ana.att;
   assign input_short = ana.shrt;
   assign rot_sel     = ana.rot;
   assign slope_high  = ctrl.slope;

   // =======================================================
   // Rate dividers
   logic xtal_tick;
   logic hb_tick;
   logic art_tick;

   // Crystal rate as an enable; no second clock domain
   lfwk_div #(
      .DIV (XTAL_DIV),
      .W   (16)
   ) u_xtal (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .en      (1'b1),
      .tick    (xtal_tick)
   );

   lfwk_div #(
      .DIV (`LFWK_HB_DIV),
      .W   (4)
   ) u_hb (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .en      (xtal_tick),
      .tick    (hb_tick)
   );

   lfwk_div #(
      .DIV (ART_TICKS),
      .W   (28)
   ) u_art (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .en      (xtal_tick),
      .tick    (art_tick)
   );

   // =======================================================
   // Correlators
   logic [2:0] hit;
   logic [2:0] run;
   logic       any_hit;

   generate
      for (genvar c = 0; c < 3; c++) begin : g_corr
         lfwk_corr u_corr (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .sample  (hb_tick),
            .din     (hb_data[c]),
            .enable  (ana.en[c]),
            .clr     (ctrl.crst),
            .tol     (ctrl.tol),
            .hit     (hit[c]),
            .running (run[c])
         );
      end
   endgenerate

   // Any channel may deliver either pattern of a pair
   assign any_hit = |hit;

   // =======================================================
   // Double pattern tracking
   logic [4:0] win;

   always_ff @(posedge ref_clk) begin
      if (!rstn || ctrl.crst || !ctrl.dbl) begin
         dbl_state <= lfwk_pkg::DBL_IDLE;
         win       <= '0;
      end else begin
         unique case (dbl_state)
            lfwk_pkg::DBL_IDLE: begin
               win <= '0;
               if (any_hit) begin
                  dbl_state <= lfwk_pkg::DBL_ARMED;
               end
            end
            lfwk_pkg::DBL_ARMED: begin
               // Second copy must complete within 18 half-bit ticks
               if (any_hit) begin
                  dbl_state <= lfwk_pkg::DBL_IDLE;
               end else if (hb_tick) begin
                  if (win == 5'(`LFWK_DBL_WIN - 1)) begin
                     dbl_state <= lfwk_pkg::DBL_IDLE;
                  end
                  win <= win + 1'b1;
               end
            end
         endcase
      end
   end

   // =======================================================
   // Wake output
   logic por_done;
   logic set_now;

   assign set_now = !por_done
                    || art_tick
                    || (any_hit && !ctrl.dbl)
                    || (any_hit && ctrl.dbl
                        && dbl_state == lfwk_pkg::DBL_ARMED);

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         por_done <= 1'b0;
         wake_n   <= 1'b1;
      end else begin
         por_done <= 1'b1;
         // Set wins over a clear in the same cycle
         if (set_now) begin
            wake_n <= 1'b0;
         end else if (wclr_fall) begin
            wake_n <= 1'b1;
         end
      end
   end

   logic [2:0] hit_seen;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         hit_seen <= '0;
      end else begin
         hit_seen <= (hit_seen & ~{3{wclr_fall}}) | hit;
      end
   end

   // =======================================================
   // Read port
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (addr)
         `LFWK_OFF_CTRL: begin
            rd_val[`LFWK_CTRL_DBL]     = ctrl.dbl;
            rd_val[`LFWK_CTRL_TOL +: 2] = ctrl.tol;
            rd_val[`LFWK_CTRL_CRST]    = ctrl.crst;
            rd_val[`LFWK_CTRL_WCLR]    = ctrl.wclr;
            rd_val[`LFWK_CTRL_SLOPE]   = ctrl.slope;
         end
         `LFWK_OFF_ANA: begin
            rd_val[`LFWK_ANA_EN +: 3]  = ana.en;
            rd_val[`LFWK_ANA_ATT +: 3] = ana.att;
            rd_val[`LFWK_ANA_SHORT]    = ana.shrt;
            rd_val[`LFWK_ANA_ROT +: 2] = ana.rot;
         end
         `LFWK_OFF_STAT: begin
            rd_val[`LFWK_STAT_WAKE]     = !wake_n;
            rd_val[`LFWK_STAT_HIT +: 3] = hit_seen;
            rd_val[`LFWK_STAT_RUN +: 3] = run;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // Data valid only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdata <= 32'h0000_0000;
      end else begin
         rdata <= rd ? rd_val : 32'h0000_0000;
      end
   end

   // =======================================================
   // Assertions
   property p_por_high;
      @(posedge ref_clk) !rstn |=> wake_n;
   endproperty
   a_por_high: assert property (p_por_high)
      else $error("wake not high during reset");

   property p_por_wake;
      @(posedge ref_clk) (!$past(rstn) && rstn) |=> !wake_n;
   endproperty
   a_por_wake: assert property (p_por_wake)
      else $error("no power-on wake after reset");

   property p_single_wake;
      @(posedge ref_clk) disable iff (!rstn)
      (any_hit && !ctrl.dbl) |=> !wake_n;
   endproperty
   a_single_wake: assert property (p_single_wake)
      else $error("match did not drive wake low");

   property p_first_of_two;
      @(posedge ref_clk) disable iff (!rstn)
      (ctrl.dbl && dbl_state == lfwk_pkg::DBL_IDLE && any_hit
       && wake_n && por_done && !art_tick)
      |=> wake_n ##0 dbl_state == lfwk_pkg::DBL_ARMED;
   endproperty
   a_first_of_two: assert property (p_first_of_two)
      else $error("single pattern woke in double mode");

   property p_clear;
      @(posedge ref_clk) disable iff (!rstn)
      (wclr_fall && !set_now) |=> wake_n;
   endproperty
   a_clear: assert property (p_clear)
      else $error("wake not released by clear toggle");

   property p_set_wins;
      @(posedge ref_clk) disable iff (!rstn)
      (wclr_fall && set_now) |=> !wake_n;
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("clear beat a wake event");

   property p_hb_rate;
      @(posedge ref_clk) disable iff (!rstn)
      hb_tick |-> $past(xtal_tick);
   endproperty
   a_hb_rate: assert property (p_hb_rate)
      else $error("half-bit tick not on crystal tick");

   property p_art_wake;
      @(posedge ref_clk) disable iff (!rstn)
      art_tick |=> !wake_n;
   endproperty
   a_art_wake: assert property (p_art_wake)
      else $error("artificial wake missing");

   property p_corr_reset;
      @(posedge ref_clk) disable iff (!rstn)
      ctrl.crst |=> (hit == 3'b000) && (run == 3'b000);
   endproperty
   a_corr_reset: assert property (p_corr_reset)
      else $error("correlator ran while held in reset");

   property p_rot_write;
      @(posedge ref_clk) disable iff (!rstn)
      wr_ana |=> rot_sel == $past(wdata[`LFWK_ANA_ROT +: 2]);
   endproperty
   a_rot_write: assert property (p_rot_write)
      else $error("rotator field not written");

   property p_off_chan;
      @(posedge ref_clk) disable iff (!rstn)
      !ana.en[0] |=> !hit[0];
   endproperty
   a_off_chan: assert property (p_off_chan)
      else $error("disabled channel reported a hit");

   property p_cv_double;
      @(posedge ref_clk) disable iff (!rstn)
      dbl_state == lfwk_pkg::DBL_ARMED && any_hit;
   endproperty
   c_double: cover property (p_cv_double);

   property p_cv_single;
      @(posedge ref_clk) disable iff (!rstn)
      any_hit && !ctrl.dbl;
   endproperty
   c_single: cover property (p_cv_single);

   property p_cv_clear;
      @(posedge ref_clk) disable iff (!rstn)
      !wake_n ##1 wclr_fall ##1 wake_n;
   endproperty
   c_clear: cover property (p_cv_clear);

   property p_cv_art;
      @(posedge ref_clk) disable iff (!rstn)
      art_tick;
   endproperty
   c_art: cover property (p_cv_art);

endmodule

`default_nettype wire

/* File: tb/lfwk_tx_model.sv */
// Purpose: Wakeup transmitter model driving the sliced half-bit lines
// Assumes: One half-bit lasts HB_CLKS reference clocks
// Notes:   Lines rest at 0 between frames, as a slicer without carrier
`timescale 1ns/1ps
`default_nettype none

module lfwk_tx_model #(
   parameter int HB_CLKS = 24
) (
   // Clock
   input  wire logic       ref_clk,
   // Sliced lines
   output var  logic [2:0] hb_data
);
   initial hb_data = 3'h0;

   // ==========================================================
   // Half-bit and frame
   task automatic half_bit(input int ch, input logic v);
      logic [2:0] t;
      t = 3'h0;
      t[ch] = v;
      @(posedge ref_clk);
      hb_data <= t;
      repeat (HB_CLKS - 1) @(posedge ref_clk);
   endtask

   // No idle after a frame lets a second pattern follow at once
   task automatic send(input int ch, input logic [15:0] pat,
                       input int npre, input bit idle);
      for (int i = 0; i < npre; i++) half_bit(ch, ~i[0]);
      for (int i = 15; i >= 0; i--) half_bit(ch, pat[i]);
      if (idle) begin
         @(posedge ref_clk);
         hb_data <= 3'h0;
      end
   endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the wakeup correlator top
// Assumes: Shortened crystal divider and artificial wake period
// Notes:   The bench plays the controller on the register port
`timescale 1ns/1ps
`default_nettype none
`include "lfwk_defs.svh"
`define CHK(got, exp, msg) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         num_errors++; \
         $display("mismatch at %0t: %s", $time, msg); \
      end \
   end

module tb;
   localparam int XDIV = 2;
   localparam int ART  = 20000;
   localparam int HB   = `LFWK_HB_DIV * XDIV;
   localparam logic [15:0] PAT = `LFWK_PATTERN;

   logic        ref_clk;
   logic        rstn;
   logic [7:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic [2:0]  hb_data;
   logic        wake_n;
   logic [2:0]  chan_en;
   logic [2:0]  atten_en;
   logic        input_short;
   logic [1:0]  rot_sel;
   logic        slope_high;
   logic [31:0] ctrl;
   logic [31:0] rv;
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   lfwk_top #(.XTAL_DIV(XDIV), .ART_TICKS(ART)) lfwk_top_inst (
      .ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .hb_data(hb_data),
      .wake_n(wake_n), .chan_en(chan_en), .atten_en(atten_en),
      .input_short(input_short), .rot_sel(rot_sel),
      .slope_high(slope_high));

   lfwk_tx_model #(.HB_CLKS(HB)) lfwk_tx_model_inst (
      .ref_clk(ref_clk), .hb_data(hb_data));

   initial ref_clk = 1'b0;
   always #2.5 ref_clk = ~ref_clk;

   // Hang guard, well above the artificial wake period
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 70000) begin
         num_errors++;
         $display("mismatch at %0t: run timed out", $time);
         tally_and_finish();
      end
   end

   // ==========================================================
   // Bus and helpers
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge ref_clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge ref_clk);
      rd   <= 1'b0;
      #1;
      rv = rdata;
   endtask

   task automatic clear_wake();
      wr_reg(`LFWK_OFF_CTRL, ctrl | 32'h0000_0010);
      wr_reg(`LFWK_OFF_CTRL, ctrl);
      #1;
      `CHK(wake_n, 1'b1, "wake not cleared")
   endtask

   task automatic frame(input int ch, input logic [15:0] p,
                        input logic exp_n);
      lfwk_tx_model_inst.send(ch, p, 8, 1);
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK(wake_n, exp_n, "wake after frame")
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_por();
      @(posedge ref_clk);
      #1;
      `CHK(wake_n, 1'b1, "wake during reset")
      @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      #1;
      `CHK(wake_n, 1'b0, "no power-on wake")
   endtask

   task automatic t_regs();
      rd_reg(`LFWK_OFF_CTRL);
      `CHK(rv, 32'h0000_0000, "ctrl reset")
      rd_reg(`LFWK_OFF_ANA);
      `CHK(rv, 32'h0000_0007, "ana reset")
      `CHK({chan_en, atten_en, input_short, rot_sel, slope_high},
           10'h380, "outputs reset")
      wr_reg(`LFWK_OFF_ANA, 32'h0000_016B);
      rd_reg(`LFWK_OFF_ANA);
      `CHK(rv, 32'h0000_016B, "ana readback")
      `CHK({chan_en, atten_en, input_short, rot_sel},
           9'h0EE, "analog outputs")
      wr_reg(`LFWK_OFF_ANA, 32'h0000_0007);
      wr_reg(`LFWK_OFF_CTRL, 32'h0000_0020);
      #1;
      `CHK(slope_high, 1'b1, "slope select")
      wr_reg(`LFWK_OFF_CTRL, ctrl);
      rd_reg(8'h0C);
      `CHK(rv, 32'h0000_0000, "unmapped read")
   endtask

   task automatic t_single();
      for (int ch = 0; ch < 3; ch++) begin
         clear_wake();
         frame(ch, PAT, 1'b0);
         repeat (50) @(posedge ref_clk);
         rd_reg(`LFWK_OFF_STAT);
         `CHK(rv[3:0], {3'h1 << ch, 1'b1}, "status hit")
         `CHK(wake_n, 1'b0, "wake did not hold")
      end
   endtask

   task automatic t_tol();
      logic [1:0]  tl[6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
      logic [15:0] pt[6] = '{16'hD669, 16'hD669, 16'hF669,
                             16'hF669, 16'hFE69, 16'h9668};
      logic        xn[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      for (int k = 0; k < 6; k++) begin
         ctrl = {29'h0, tl[k], 1'b0};
         wr_reg(`LFWK_OFF_CTRL, ctrl);
         clear_wake();
         frame(0, pt[k], xn[k]);
      end
      ctrl = 32'h0000_0000;
      wr_reg(`LFWK_OFF_CTRL, ctrl);
      clear_wake();
   endtask

   task automatic t_double();
      ctrl = 32'h0000_0001;
      wr_reg(`LFWK_OFF_CTRL, ctrl);
      clear_wake();
      frame(0, PAT, 1'b1);
      repeat (20 * HB) @(posedge ref_clk);
      #1;
      `CHK(wake_n, 1'b1, "single pattern woke in double")
      lfwk_tx_model_inst.send(0, PAT, 8, 0);
      lfwk_tx_model_inst.send(1, PAT, 0, 1);
      repeat (4) @(posedge ref_clk);
      #1;
      `CHK(wake_n, 1'b0, "double across channels")
      ctrl = 32'h0000_0000;
      wr_reg(`LFWK_OFF_CTRL, ctrl);
      clear_wake();
   endtask

   task automatic t_gate();
      wr_reg(`LFWK_OFF_CTRL, 32'h0000_0008);
      frame(1, PAT, 1'b1);
      wr_reg(`LFWK_OFF_CTRL, ctrl);
      wr_reg(`LFWK_OFF_ANA, 32'h0000_0006);
      frame(0, PAT, 1'b1);
      frame(2, PAT, 1'b0);
      wr_reg(`LFWK_OFF_ANA, 32'h0000_0007);
      clear_wake();
   endtask

   task automatic t_idle();
      repeat (34 * HB) @(posedge ref_clk);
      rd_reg(`LFWK_OFF_STAT);
      `CHK(rv[6:4], 3'h0, "correlators still running")
      frame(1, PAT, 1'b0);
      clear_wake();
   endtask

   task automatic t_artificial();
      int n;
      n = 0;
      while (wake_n === 1'b1 && n < ART * XDIV + 100) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      `CHK(wake_n, 1'b0, "no artificial wake")
      // Period counts from reset release, plus divider latency
      `CHK((cycles >= ART * XDIV) && (cycles <= ART * XDIV + 8),
           1'b1, "artificial wake period")
      clear_wake();
   endtask

   // ==========================================================
   // Sequence and verdict
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      rstn  = 1'b0;
      addr  = 8'h00;
      wdata = 32'h0000_0000;
      wr    = 1'b0;
      rd    = 1'b0;
      ctrl  = 32'h0000_0000;
      t_por();
      t_regs();
      t_single();
      t_tol();
      t_double();
      t_gate();
      t_idle();
      t_artificial();
      tally_and_finish();
   end
endmodule

`default_nettype wire
